//--- logic/hk_adc_seq.sv
`timescale 1ns/1ps
module hk_adc_seq #(
  parameter longint unsigned MINUTE_CYCLES = hk_pkg::MINUTE_CYC
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // special function register port
  input wire logic [7:0] sfr_addr_i,
  input wire logic sfr_wr_i,
  input wire logic [7:0] sfr_wdata_i,
  output logic [7:0] sfr_rdata_o,
  // system state
  input wire hk_pkg::hk_psm_t pwr_state_i,
  input wire logic rtc_run_enable_i,
  input wire logic pll_lock_lost_i,
  output logic pll_fault_flag_o,
  // shared converter handshake
  output logic conv_req_o,
  output hk_pkg::hk_chan_e conv_chan_o,
  input wire logic conv_accept_i,
  input wire logic conv_done_i,
  input wire logic [7:0] conv_data_i,
  // interrupts
  output logic temp_irq_o,
  output logic batt_irq_o,
  output logic ext_irq_o,
  output logic psm_irq_o
);
  import hk_pkg::*;

  typedef enum logic [1:0] {ST_IDLE, ST_REQ, ST_WAIT, ST_DRAIN} hk_state_e;

  // ****************************************
  // input synchronisers
  // ****************************************
  logic acc_s1_q, acc_s2_q, done_s1_q, done_s2_q, pll_s1_q, pll_s2_q;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      acc_s1_q <= 1'b0;
      acc_s2_q <= 1'b0;
      done_s1_q <= 1'b0;
      done_s2_q <= 1'b0;
      pll_s1_q <= 1'b0;
      pll_s2_q <= 1'b0;
    end else begin
      acc_s1_q <= conv_accept_i;
      acc_s2_q <= acc_s1_q;
      done_s1_q <= conv_done_i;
      done_s2_q <= done_s1_q;
      pll_s1_q <= pll_lock_lost_i;
      pll_s2_q <= pll_s1_q;
    end
  end

  // ****************************************
  // background schedule
  // ****************************************
  hk_strobe_if sb ();
  logic [7:0] strobe_q, strobe_d;

  assign sb.run_en = rtc_run_enable_i;
  assign sb.temp_sel = strobe_q[TEMP_SEL_LSB +: 2];
  assign sb.batt_sel = strobe_q[BATT_SEL_LSB +: 2];

  hk_strobe_gen #(.MINUTE_CYCLES(MINUTE_CYCLES)) u_strobe (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .sb(sb)
  );

  function automatic logic [7:0] abs_diff(input logic [7:0] a, input logic [7:0] b);
    abs_diff = (a > b) ? a - b : b - a;
  endfunction : abs_diff

  // ****************************************
  // state
  // ****************************************
  hk_state_e state_q, state_d;
  hk_chan_e chan_q, chan_d;
  logic bg_q, bg_d;
  logic [2:0] go_q, go_d;
  logic [1:0] bgp_q, bgp_d;
  logic [7:0] delta_q, delta_d, thr_q, thr_d, en_q, en_d, flags_q, flags_d;
  logic [7:0] temp_q, temp_d, batt_q, batt_d, ext_q, ext_d, ref_q, ref_d;
  logic [7:0] rdata_q, rdata_d;
  logic pll_q, pll_d, req_q, req_d;
  logic tirq_q, tirq_d, birq_q, birq_d, eirq_q, eirq_d, pirq_q, pirq_d;
  logic single_ok, tbg_ok, bbg_ok, wr, below;
  logic [2:0] tdelta;

  always_comb begin
    state_d = state_q;
    chan_d = chan_q;
    bg_d = bg_q;
    go_d = go_q;
    delta_d = delta_q;
    thr_d = thr_q;
    en_d = en_q;
    flags_d = flags_q;
    strobe_d = strobe_q;
    temp_d = temp_q;
    batt_d = batt_q;
    ext_d = ext_q;
    ref_d = ref_q;
    pll_d = pll_q;
    req_d = req_q;
    tirq_d = 1'b0;
    birq_d = 1'b0;
    eirq_d = 1'b0;
    wr = sfr_wr_i;
    tdelta = delta_q[TEMP_DELTA_LSB +: 3];
    below = conv_data_i < thr_q;
    // a halted core cannot ask, battery power stops the schedule
    single_ok = pwr_state_i != PSM_SLEEP;
    tbg_ok = pwr_state_i != PSM_BATT_ACTIVE;
    bbg_ok = pwr_state_i == PSM_FULL;
    // background requests not allowed in this state are dropped, not delayed
    bgp_d = bgp_q & {bbg_ok, tbg_ok};
    // ---- register writes; hardware sets below take precedence
    if (wr) begin
      case (sfr_addr_i)
        ADDR_CONV_START: begin
          go_d = go_q | sfr_wdata_i[2:0];
          if (sfr_wdata_i[PLL_ACK_BIT]) begin
            pll_d = 1'b0;
          end
        end
        ADDR_LOW_BATT_THR: thr_d = sfr_wdata_i;
        ADDR_STROBE_PERIOD: strobe_d = sfr_wdata_i & STROBE_MASK;
        ADDR_DELTA_CONFIG: delta_d = sfr_wdata_i & DELTA_MASK;
        ADDR_PWR_ENABLES: en_d = sfr_wdata_i;
        ADDR_PWR_FLAGS: flags_d = flags_q & sfr_wdata_i;
        default: ;
      endcase
    end
    if (pll_s2_q) begin
      pll_d = 1'b1;
    end
    if (sb.temp_strobe && tbg_ok) begin
      bgp_d[0] = 1'b1;
    end
    if (sb.batt_strobe && bbg_ok) begin
      bgp_d[1] = 1'b1;
    end
    // ---- sequencer
    case (state_q)
      ST_IDLE: begin
        // fixed priority: singles first, temperature before battery
        if (single_ok && go_q[GO_TEMP]) begin
          chan_d = CH_TEMP;
          bg_d = 1'b0;
          state_d = ST_REQ;
        end else if (single_ok && go_q[GO_BATT]) begin
          chan_d = CH_BATT;
          bg_d = 1'b0;
          state_d = ST_REQ;
        end else if (single_ok && go_q[GO_EXT]) begin
          chan_d = CH_EXT;
          bg_d = 1'b0;
          state_d = ST_REQ;
        end else if (bgp_d[0]) begin
          chan_d = CH_TEMP;
          bg_d = 1'b1;
          bgp_d[0] = 1'b0;
          state_d = ST_REQ;
        end else if (bgp_d[1]) begin
          chan_d = CH_BATT;
          bg_d = 1'b1;
          bgp_d[1] = 1'b0;
          state_d = ST_REQ;
        end
        req_d = state_d == ST_REQ;
      end
      ST_REQ: begin
        if (acc_s2_q) begin
          req_d = 1'b0;
          state_d = ST_WAIT;
          if (!bg_q) begin
            case (chan_q)
              CH_TEMP: go_d[GO_TEMP] = 1'b0;
              CH_BATT: go_d[GO_BATT] = 1'b0;
              default: go_d[GO_EXT] = 1'b0;
            endcase
            // a fresh write in this cycle re-arms the bit
            if (wr && sfr_addr_i == ADDR_CONV_START) begin
              go_d = go_d | sfr_wdata_i[2:0];
            end
          end
        end
      end
      ST_WAIT: begin
        if (done_s2_q) begin
          state_d = ST_DRAIN;
          case (chan_q)
            CH_TEMP: begin
              if (!bg_q || tdelta == DELTA_EVERY ||
                  (tdelta != DELTA_NONE && abs_diff(conv_data_i, ref_q) > {5'h00, tdelta}))
              begin
                tirq_d = 1'b1;
                temp_d = conv_data_i;
                ref_d = conv_data_i;
              end
            end
            CH_BATT: begin
              if (!bg_q || below) begin
                birq_d = 1'b1;
                batt_d = conv_data_i;
                flags_d[LOW_BATT_FLAG_BIT] = 1'b1;
              end
            end
            default: begin
              eirq_d = 1'b1;
              ext_d = conv_data_i;
            end
          endcase
        end
      end
      ST_DRAIN: begin
        if (!acc_s2_q && !done_s2_q) begin
          state_d = ST_IDLE;
        end
      end
      default: state_d = ST_IDLE;
    endcase
    pirq_d = flags_d[LOW_BATT_FLAG_BIT] && en_d[LOW_BATT_IRQ_EN_BIT];
    // ---- read mux, answered one cycle after the address
    case (sfr_addr_i)
      ADDR_TEMP_RESULT: rdata_d = temp_q;
      ADDR_CONV_START: rdata_d = {5'h00, go_q};
      ADDR_BATT_RESULT: rdata_d = batt_q;
      ADDR_EXT_RESULT: rdata_d = ext_q;
      ADDR_LOW_BATT_THR: rdata_d = thr_q;
      ADDR_STROBE_PERIOD: rdata_d = strobe_q;
      ADDR_DELTA_CONFIG: rdata_d = delta_q;
      ADDR_PWR_ENABLES: rdata_d = en_q;
      ADDR_PWR_FLAGS: rdata_d = flags_q;
      default: rdata_d = RESET_BYTE;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_q <= ST_IDLE;
      chan_q <= CH_BATT;
      bg_q <= 1'b0;
      go_q <= '0;
      bgp_q <= '0;
      delta_q <= RESET_BYTE;
      thr_q <= RESET_BYTE;
      en_q <= RESET_BYTE;
      flags_q <= RESET_BYTE;
      strobe_q <= RESET_BYTE;
      temp_q <= RESET_BYTE;
      batt_q <= RESET_BYTE;
      ext_q <= RESET_BYTE;
      ref_q <= RESET_BYTE;
      rdata_q <= RESET_BYTE;
      pll_q <= 1'b0;
      req_q <= 1'b0;
      tirq_q <= 1'b0;
      birq_q <= 1'b0;
      eirq_q <= 1'b0;
      pirq_q <= 1'b0;
    end else begin
      state_q <= state_d;
      chan_q <= chan_d;
      bg_q <= bg_d;
      go_q <= go_d;
      bgp_q <= bgp_d;
      delta_q <= delta_d;
      thr_q <= thr_d;
      en_q <= en_d;
      flags_q <= flags_d;
      strobe_q <= strobe_d;
      temp_q <= temp_d;
      batt_q <= batt_d;
      ext_q <= ext_d;
      ref_q <= ref_d;
      rdata_q <= rdata_d;
      pll_q <= pll_d;
      req_q <= req_d;
      tirq_q <= tirq_d;
      birq_q <= birq_d;
      eirq_q <= eirq_d;
      pirq_q <= pirq_d;
    end
  end

  assign sfr_rdata_o = rdata_q;
  assign pll_fault_flag_o = pll_q;
  assign conv_req_o = req_q;
  assign conv_chan_o = chan_q;
  assign temp_irq_o = tirq_q;
  assign batt_irq_o = birq_q;
  assign ext_irq_o = eirq_q;
  assign psm_irq_o = pirq_q;

  // ****************************************
  // checks
  // ****************************************
  property p_pll_ack;
    @(posedge clk_i) disable iff (rst_i)
    (sfr_wr_i && sfr_addr_i == ADDR_CONV_START && sfr_wdata_i[PLL_ACK_BIT] && !pll_s2_q)
      |=> !pll_fault_flag_o;
  endproperty
  a_pll_ack: assert property (p_pll_ack)
    else $error("pll fault flag not cleared by acknowledge");

  property p_req_drops;
    @(posedge clk_i) disable iff (rst_i)
    (conv_req_o && acc_s2_q && !bg_q && chan_q == CH_TEMP && !sfr_wr_i)
      |=> !conv_req_o && !go_q[GO_TEMP];
  endproperty
  a_req_drops: assert property (p_req_drops)
    else $error("start bit or request held after accept");

  property p_low_batt;
    @(posedge clk_i) disable iff (rst_i)
    (state_q == ST_WAIT && done_s2_q && chan_q == CH_BATT && below)
      |=> flags_q[LOW_BATT_FLAG_BIT] && batt_irq_o && batt_q == $past(conv_data_i);
  endproperty
  a_low_batt: assert property (p_low_batt)
    else $error("low battery result did not set flag");

  property p_temp_load;
    @(posedge clk_i) disable iff (rst_i)
    $changed(temp_q) |-> temp_irq_o;
  endproperty
  a_temp_load: assert property (p_temp_load)
    else $error("temperature result changed without interrupt");

  property p_delta_off;
    @(posedge clk_i) disable iff (rst_i)
    (state_q == ST_WAIT && done_s2_q && chan_q == CH_TEMP && bg_q && tdelta == DELTA_NONE)
      |=> !temp_irq_o;
  endproperty
  a_delta_off: assert property (p_delta_off)
    else $error("background temperature interrupt with delta off");

  property p_no_bg_batt_active;
    @(posedge clk_i) disable iff (rst_i)
    ($rose(conv_req_o) && bg_q) |-> $past(pwr_state_i) != PSM_BATT_ACTIVE;
  endproperty
  a_no_bg_batt_active: assert property (p_no_bg_batt_active)
    else $error("background conversion on battery power");

  property p_no_batt_sleep;
    @(posedge clk_i) disable iff (rst_i)
    ($rose(conv_req_o) && chan_q == CH_BATT) |-> $past(pwr_state_i) != PSM_SLEEP;
  endproperty
  a_no_batt_sleep: assert property (p_no_batt_sleep)
    else $error("battery conversion started in sleep");

  property p_ref_on_irq;
    @(posedge clk_i) disable iff (rst_i)
    $changed(ref_q) |-> temp_irq_o && ref_q == temp_q;
  endproperty
  a_ref_on_irq: assert property (p_ref_on_irq)
    else $error("temperature reference moved without interrupt");

  property p_psm_gate;
    @(posedge clk_i) disable iff (rst_i)
    psm_irq_o |-> flags_q[LOW_BATT_FLAG_BIT] && en_q[LOW_BATT_IRQ_EN_BIT];
  endproperty
  a_psm_gate: assert property (p_psm_gate)
    else $error("power interrupt without enabled flag");
endmodule : hk_adc_seq

//--- logic/hk_pkg.sv
package hk_pkg;
  // ****************************************
  // register map
  // ****************************************
  localparam logic [7:0] ADDR_TEMP_RESULT = 8'hD7;
  localparam logic [7:0] ADDR_CONV_START = 8'hD8;
  localparam logic [7:0] ADDR_BATT_RESULT = 8'hDF;
  localparam logic [7:0] ADDR_EXT_RESULT = 8'hEF;
  localparam logic [7:0] ADDR_LOW_BATT_THR = 8'hFA;
  localparam logic [7:0] ADDR_STROBE_PERIOD = 8'hF9;
  localparam logic [7:0] ADDR_DELTA_CONFIG = 8'hF3;
  localparam logic [7:0] ADDR_PWR_FLAGS = 8'hF8;
  localparam logic [7:0] ADDR_PWR_ENABLES = 8'hEC;
  localparam logic [7:0] RESET_BYTE = 8'h00;
  // ****************************************
  // fields
  // ****************************************
  localparam int GO_BATT = 0;
  localparam int GO_TEMP = 1;
  localparam int GO_EXT = 2;
  localparam int PLL_ACK_BIT = 7;
  localparam int LOW_BATT_FLAG_BIT = 0;
  localparam int LOW_BATT_IRQ_EN_BIT = 0;
  localparam int TEMP_SEL_LSB = 0;
  localparam int BATT_SEL_LSB = 2;
  localparam int TEMP_DELTA_LSB = 3;
  localparam logic [7:0] STROBE_MASK = 8'h3F;
  localparam logic [7:0] DELTA_MASK = 8'h3F;
  localparam logic [2:0] DELTA_NONE = 3'h0;
  localparam logic [2:0] DELTA_EVERY = 3'h7;
  // ****************************************
  // power states and channels
  // ****************************************
  typedef logic [1:0] hk_psm_t;
  localparam hk_psm_t PSM_FULL = 2'h0;
  localparam hk_psm_t PSM_BATT_ACTIVE = 2'h1;
  localparam hk_psm_t PSM_SLEEP = 2'h2;
  typedef enum logic [1:0] {CH_BATT, CH_TEMP, CH_EXT} hk_chan_e;
  // ****************************************
  // strobe timing
  // ****************************************
  localparam longint unsigned CLK_HZ = 64'd100000000;
  localparam longint unsigned MINUTE_S = 64'd60;
  localparam longint unsigned MINUTE_CYC = MINUTE_S * CLK_HZ;
  localparam int PRESC_W = 36;
  localparam int MIN_W = 4;
  localparam logic [4:0] TEMP_MIN_01 = 5'h08;
  localparam logic [4:0] TEMP_MIN_10 = 5'h02;
  localparam logic [4:0] BATT_MIN_01 = 5'h10;
  localparam logic [4:0] BATT_MIN_10 = 5'h04;
  localparam logic [4:0] MIN_11 = 5'h01;
  localparam logic [4:0] MIN_OFF = 5'h00;
endpackage : hk_pkg

//--- logic/hk_strobe_gen.sv
`timescale 1ns/1ps
module hk_strobe_gen #(
  parameter longint unsigned MINUTE_CYCLES = hk_pkg::MINUTE_CYC
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // schedule
  hk_strobe_if.gen sb
);
  import hk_pkg::*;

  logic [PRESC_W-1:0] presc_q, presc_d;
  logic [MIN_W-1:0] min_q, min_d;
  logic ts_q, ts_d, bs_q, bs_d;
  logic tick;

  // minutes between strobes for an interval code
  function automatic logic [4:0] period_min(input logic [1:0] sel, input logic is_batt);
    case (sel)
      2'h1: period_min = is_batt ? BATT_MIN_01 : TEMP_MIN_01;
      2'h2: period_min = is_batt ? BATT_MIN_10 : TEMP_MIN_10;
      2'h3: period_min = MIN_11;
      default: period_min = MIN_OFF;
    endcase
  endfunction : period_min

  function automatic logic due(input logic [1:0] sel, input logic is_batt,
                               input logic [MIN_W-1:0] m);
    logic [4:0] p;
    p = period_min(sel, is_batt);
    due = (p != MIN_OFF) && (({1'b0, m} & (p - 5'h01)) == 5'h00);
  endfunction : due

  always_comb begin
    tick = presc_q == PRESC_W'(MINUTE_CYCLES - 64'd1);
    presc_d = tick ? '0 : presc_q + PRESC_W'(1);
    min_d = tick ? min_q + MIN_W'(1) : min_q;
    ts_d = tick && due(sb.temp_sel, 1'b0, min_d);
    bs_d = tick && due(sb.batt_sel, 1'b1, min_d);
    // stopped rtc freezes the schedule at its origin
    if (!sb.run_en) begin
      presc_d = '0;
      min_d = '0;
      ts_d = 1'b0;
      bs_d = 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      presc_q <= '0;
      min_q <= '0;
      ts_q <= 1'b0;
      bs_q <= 1'b0;
    end else begin
      presc_q <= presc_d;
      min_q <= min_d;
      ts_q <= ts_d;
      bs_q <= bs_d;
    end
  end

  assign sb.temp_strobe = ts_q;
  assign sb.batt_strobe = bs_q;

  property p_strobe_needs_run;
    @(posedge clk_i) disable iff (rst_i)
    (ts_q || bs_q) |-> $past(sb.run_en);
  endproperty
  a_strobe_needs_run: assert property (p_strobe_needs_run)
    else $error("strobe while rtc stopped");

  property p_off_no_strobe;
    @(posedge clk_i) disable iff (rst_i)
    ts_q |-> $past(sb.temp_sel) != 2'h0;
  endproperty
  a_off_no_strobe: assert property (p_off_no_strobe)
    else $error("temperature strobe with interval off");
endmodule : hk_strobe_gen

//--- logic/hk_strobe_if.sv
`timescale 1ns/1ps
interface hk_strobe_if;
  logic run_en;
  logic [1:0] temp_sel;
  logic [1:0] batt_sel;
  logic temp_strobe;
  logic batt_strobe;
  modport gen (input run_en, input temp_sel, input batt_sel, output temp_strobe,
               output batt_strobe);
  modport seq (output run_en, output temp_sel, output batt_sel, input temp_strobe,
               input batt_strobe);
endinterface : hk_strobe_if

//--- tb/hk_adc_seq_tb.sv
`timescale 1ns/1ps
module hk_adc_seq_tb;
  import hk_pkg::*;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [7:0] sfr_addr_i = 8'h00;
  logic sfr_wr_i = 1'b0;
  logic [7:0] sfr_wdata_i = 8'h00;
  logic [7:0] sfr_rdata_o;
  hk_psm_t pwr_state_i = PSM_FULL;
  logic rtc_run_enable_i = 1'b0;
  logic pll_lock_lost_i = 1'b0;
  logic pll_fault_flag_o, conv_req_o, conv_accept_i, conv_done_i;
  hk_chan_e conv_chan_o;
  logic [7:0] conv_data_i;
  logic temp_irq_o, batt_irq_o, ext_irq_o, psm_irq_o;
  logic [7:0] temp_val = 8'h40, batt_val = 8'h60, ext_val = 8'h33;
  logic slow = 1'b0;
  logic [7:0] regs [10] = '{ADDR_TEMP_RESULT, ADDR_CONV_START, ADDR_BATT_RESULT,
    ADDR_EXT_RESULT, ADDR_LOW_BATT_THR, ADDR_STROBE_PERIOD, ADDR_DELTA_CONFIG,
    ADDR_PWR_FLAGS, ADDR_PWR_ENABLES, 8'h10};
  int n_mismatch = 0;
  int comparisons = 0;
  int cnt_t = 0, cnt_b = 0, cnt_e = 0, t0, b0, e0;
  always #5 clk_i = ~clk_i;
  // short minute keeps every interval inside a few hundred cycles
  hk_adc_seq #(.MINUTE_CYCLES(40)) hk_adc_seq_inst (.clk_i(clk_i), .rst_i(rst_i),
    .sfr_addr_i(sfr_addr_i), .sfr_wr_i(sfr_wr_i), .sfr_wdata_i(sfr_wdata_i),
    .sfr_rdata_o(sfr_rdata_o), .pwr_state_i(pwr_state_i),
    .rtc_run_enable_i(rtc_run_enable_i), .pll_lock_lost_i(pll_lock_lost_i),
    .pll_fault_flag_o(pll_fault_flag_o), .conv_req_o(conv_req_o),
    .conv_chan_o(conv_chan_o), .conv_accept_i(conv_accept_i), .conv_done_i(conv_done_i),
    .conv_data_i(conv_data_i), .temp_irq_o(temp_irq_o), .batt_irq_o(batt_irq_o),
    .ext_irq_o(ext_irq_o), .psm_irq_o(psm_irq_o));
  hk_conv_model hk_conv_model_inst (.clk_i(clk_i), .rst_i(rst_i), .req_i(conv_req_o),
    .chan_i(conv_chan_o), .temp_val_i(temp_val), .batt_val_i(batt_val),
    .ext_val_i(ext_val), .slow_i(slow), .accept_o(conv_accept_i), .done_o(conv_done_i),
    .data_o(conv_data_i));
  always @(posedge clk_i) begin
    if (temp_irq_o === 1'b1) cnt_t <= cnt_t + 1;
    if (batt_irq_o === 1'b1) cnt_b <= cnt_b + 1;
    if (ext_irq_o === 1'b1) cnt_e <= cnt_e + 1;
  end
  // ****************************************
  // access and compare tasks
  // ****************************************
  task automatic chk8(input logic [7:0] g, input logic [7:0] e);
    comparisons++;
    if (g !== e) begin
      n_mismatch++;
      $display("CHECK FAILED at %0t: byte %h expected %h", $time, g, e);
    end
  endtask : chk8
  task automatic chk1(input logic g, input logic e);
    comparisons++;
    if (g !== e) begin
      n_mismatch++;
      $display("CHECK FAILED at %0t: flag %b expected %b", $time, g, e);
    end
  endtask : chk1
  task automatic chkn(input int g, input int e);
    comparisons++;
    if (g != e) begin
      n_mismatch++;
      $display("CHECK FAILED at %0t: count %0d expected %0d", $time, g, e);
    end
  endtask : chkn
  task automatic step(input int n);
    repeat (n) @(posedge clk_i);
  endtask : step
  task automatic snap();
    t0 = cnt_t;
    b0 = cnt_b;
    e0 = cnt_e;
  endtask : snap
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    sfr_addr_i <= a;
    sfr_wr_i <= 1'b1;
    sfr_wdata_i <= d;
    @(posedge clk_i);
    sfr_wr_i <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk_i);
    sfr_addr_i <= a;
    repeat (2) @(posedge clk_i);
    #1 chk8(sfr_rdata_o, e);
    // return to the edge so that later stimulus stays on it
    @(posedge clk_i);
  endtask : rd
  task automatic rtc(input logic en);
    @(posedge clk_i);
    rtc_run_enable_i <= en;
  endtask : rtc
  task automatic wrap_up();
    if (n_mismatch == 0 && comparisons > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : wrap_up
  initial begin
    repeat (30000) @(posedge clk_i);
    n_mismatch++;
    $display("CHECK FAILED at %0t: timeout", $time);
    wrap_up();
  end
  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    step(20);
    rst_i <= 1'b0;
    foreach (regs[i]) rd(regs[i], RESET_BYTE);
    wr(ADDR_LOW_BATT_THR, 8'h55);
    rd(ADDR_LOW_BATT_THR, 8'h55);
    wr(ADDR_TEMP_RESULT, 8'hAA);
    rd(ADDR_TEMP_RESULT, 8'h00);
    snap();
    wr(ADDR_CONV_START, 8'h02);
    step(60);
    chkn(cnt_t - t0, 1);
    rd(ADDR_TEMP_RESULT, 8'h40);
    rd(ADDR_CONV_START, 8'h00);
    wr(ADDR_CONV_START, 8'h04);
    step(60);
    chkn(cnt_e - e0, 1);
    rd(ADDR_EXT_RESULT, 8'h33);
    slow <= 1'b1;
    snap();
    wr(ADDR_CONV_START, 8'h03);
    step(150);
    chkn(cnt_t - t0 + cnt_b - b0, 2);
    rd(ADDR_BATT_RESULT, 8'h60);
    rd(ADDR_PWR_FLAGS, 8'h01);
    chk1(psm_irq_o, 1'b0);
    wr(ADDR_PWR_ENABLES, 8'h01);
    step(2);
    chk1(psm_irq_o, 1'b1);
    wr(ADDR_PWR_FLAGS, 8'h00);
    step(2);
    chk1(psm_irq_o, 1'b0);
    slow <= 1'b0;
    pll_lock_lost_i <= 1'b1;
    step(6);
    pll_lock_lost_i <= 1'b0;
    step(4);
    chk1(pll_fault_flag_o, 1'b1);
    wr(ADDR_CONV_START, 8'h80);
    step(2);
    chk1(pll_fault_flag_o, 1'b0);
    wr(ADDR_DELTA_CONFIG, 8'h10);
    wr(ADDR_STROBE_PERIOD, 8'h02);
    temp_val <= 8'h42;
    snap();
    rtc(1'b1);
    step(300);
    chkn(cnt_t - t0, 0);
    temp_val <= 8'h43;
    step(200);
    chkn(cnt_t - t0, 1);
    rd(ADDR_TEMP_RESULT, 8'h43);
    rtc(1'b0);
    step(60);
    wr(ADDR_DELTA_CONFIG, 8'h38);
    wr(ADDR_STROBE_PERIOD, 8'h01);
    snap();
    rtc(1'b1);
    step(700);
    chkn(cnt_t - t0, 2);
    rtc(1'b0);
    step(60);
    wr(ADDR_STROBE_PERIOD, 8'h02);
    snap();
    rtc(1'b1);
    step(700);
    chkn(cnt_t - t0, 8);
    wr(ADDR_DELTA_CONFIG, 8'h00);
    temp_val <= 8'h90;
    snap();
    step(300);
    chkn(cnt_t - t0, 0);
    pwr_state_i <= PSM_BATT_ACTIVE;
    wr(ADDR_DELTA_CONFIG, 8'h38);
    wr(ADDR_STROBE_PERIOD, 8'h0E);
    snap();
    step(300);
    chkn(cnt_t - t0, 0);
    chkn(cnt_b - b0, 0);
    wr(ADDR_CONV_START, 8'h02);
    step(60);
    chkn(cnt_t - t0, 1);
    pwr_state_i <= PSM_SLEEP;
    batt_val <= 8'h20;
    wr(ADDR_CONV_START, 8'h01);
    wr(ADDR_STROBE_PERIOD, 8'h0A);
    snap();
    step(400);
    chkn(int'(cnt_t > t0), 1);
    chkn(cnt_b - b0, 0);
    rd(ADDR_CONV_START, 8'h01);
    pwr_state_i <= PSM_FULL;
    snap();
    step(400);
    chkn(int'(cnt_b - b0 >= 2), 1);
    rd(ADDR_BATT_RESULT, 8'h20);
    rd(ADDR_PWR_FLAGS, 8'h01);
    chk1(psm_irq_o, 1'b1);
    rtc(1'b0);
    step(60);
    snap();
    step(300);
    chkn(cnt_t - t0 + cnt_b - b0, 0);
    wrap_up();
  end
endmodule : hk_adc_seq_tb

//--- tb/hk_conv_model.sv
`timescale 1ns/1ps
module hk_conv_model (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // request and values to convert
  input wire logic req_i,
  input wire hk_pkg::hk_chan_e chan_i,
  input wire logic [7:0] temp_val_i,
  input wire logic [7:0] batt_val_i,
  input wire logic [7:0] ext_val_i,
  input wire logic slow_i,
  // answer
  output logic accept_o,
  output logic done_o,
  output logic [7:0] data_o
);
  import hk_pkg::*;
  logic [7:0] v;
  initial begin
    accept_o = 1'b0;
    done_o = 1'b0;
    data_o = 8'hA5;
    forever begin
      @(posedge clk_i);
      if (!rst_i && req_i) begin
        v = (chan_i == CH_TEMP) ? temp_val_i : (chan_i == CH_EXT) ? ext_val_i : batt_val_i;
        // a slow converter stretches both the accept and the conversion time
        repeat (slow_i ? 6 : 1) @(posedge clk_i);
        accept_o <= 1'b1;
        while (req_i) @(posedge clk_i);
        accept_o <= 1'b0;
        repeat (slow_i ? 9 : 2) @(posedge clk_i);
        data_o <= v;
        done_o <= 1'b1;
        repeat (5) @(posedge clk_i);
        done_o <= 1'b0;
        // released bus shows the inverse so a late sample is caught
        data_o <= ~v;
      end
    end
  end
endmodule : hk_conv_model
